// [src/lpm_clock_map.svh]
`ifndef LPM_CLOCK_MAP_SVH
`define LPM_CLOCK_MAP_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define MODE_CTRL_OFS      12'h000
`define MODE_STATUS_OFS    12'h004

// ----------------------------------------------------------------
// mode control fields
// ----------------------------------------------------------------
`define MODE_SEL_LSB       0
`define MODE_SEL_MSB       2
`define BIAS_USED_BIT      3
`define AUX_SRC_BIT        4
`define MODE_CTRL_RESET    32'h0000_0008

// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define ST_STATE_LSB       0
`define ST_LEVEL_LSB       2
`define ST_GATES_LSB       5

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS      40
`define WAKE_MAX_NS        6000
`define BIAS_START_NS      2000
`define WAKE_MAX_CYC       (`WAKE_MAX_NS / `CLK_PERIOD_NS)
`define BIAS_START_CYC     ((`BIAS_START_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [src/lpm_clock_pkg.sv]
package lpm_clock_pkg;

    typedef enum logic [2:0] {
        MODE_RUN  = 3'h0,
        MODE_SLP0 = 3'h1,
        MODE_SLP1 = 3'h2,
        MODE_SLP2 = 3'h3,
        MODE_SLP3 = 3'h4,
        MODE_SLP4 = 3'h5
    } mode_t;

    // gray codes along run -> sleep -> wake -> handler
    typedef enum logic [1:0] {
        ST_RUN   = 2'h0,
        ST_SLEEP = 2'h1,
        ST_WAKE  = 2'h3,
        ST_ISR   = 2'h2
    } state_t;

    typedef struct packed {
        logic xtal;
        logic dcgen;
        logic aclk;
        logic subclk;
        logic mclk;
        logic cpu;
    } gate_t;

endpackage : lpm_clock_pkg

// [src/pin_sync3.sv]
`timescale 1ns/1ns
`default_nettype none

module pin_sync3 (
    input  wire logic clk,     // system clock
    input  wire logic resetn,  // async reset, active low
    input  wire logic pin,     // asynchronous input
    output logic      level    // filtered level
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // a change counts only once the last two stages agree
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            level <= 1'b0;
        end else if (s2_q == s3_q) begin
            level <= s3_q;
        end
    end

endmodule : pin_sync3

`default_nettype wire

// [src/settle_timer.sv]
`timescale 1ns/1ns
`default_nettype none

module settle_timer #(
    parameter int W = 8
) (
    input  wire logic         clk,      // system clock
    input  wire logic         resetn,   // async reset, active low
    input  wire logic         load,     // start a count
    input  wire logic [W-1:0] load_val, // cycles to wait, at least one
    output logic              busy      // count still running
);
    logic [W-1:0] cnt_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= '0;
        end else if (load) begin
            cnt_q <= load_val;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    assign busy = (cnt_q != '0);

endmodule : settle_timer

`default_nettype wire

// [src/lpm_clock_ctrl.sv]
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "lpm_clock_map.svh"

// Behaviour
// (RULE1) run mode keeps every clock and CPU on
// (RULE2) level 0: CPU, main clock off; others run
// (RULE3) level 1 as 0; bias off if unused
// (RULE4) level 2: main, sub-main off; bias, aux on
// (RULE5) level 3: main, sub-main, bias off; aux on
// (RULE6) level 4: everything off, crystal stopped
// (RULE7) interrupt wakes; return re-enters the level
// (RULE8) software picks run or one sleep level
// (RULE9) wake-up finishes within the wake-up time
// (RULE10) main clock feeds CPU, sub-main feeds peripherals
// (RULE11) aux clock source: watch or fast crystal
// (RULE12) main clock before CPU; level kept for return
module lpm_clock_ctrl #(
    parameter int START_CYC = `BIAS_START_CYC,
    parameter int WAKE_CYC  = `WAKE_MAX_CYC
) (
    input  wire logic        clk,             // system clock, 25 MHz
    input  wire logic        resetn,          // async reset, active low
    input  wire logic        psel,            // apb select
    input  wire logic        penable,         // apb access phase
    input  wire logic        pwrite,          // apb direction
    input  wire logic [11:0] paddr,           // apb byte address
    input  wire logic [31:0] pwdata,          // apb write data
    output logic      [31:0] prdata,          // apb read data
    output logic             pready,          // apb ready
    output logic             pslverr,         // apb error
    input  wire logic        irq_pending,     // interrupt request from core
    input  wire logic        irq_return,      // handler return pulse
    input  wire logic        wake_pin,        // asynchronous wake input
    output logic             cpu_en,          // CPU enable
    output logic             main_clk_en,     // main clock gate
    output logic             sub_main_clk_en, // sub-main clock gate
    output logic             aux_clk_en,      // auxiliary clock gate
    output logic             dcgen_en,        // oscillator bias enable
    output logic             xtal_en,         // crystal oscillator enable
    output logic             aux_src_hf       // aux source: 1 fast crystal
);
    import lpm_clock_pkg::*;

    localparam int TW         = $clog2(START_CYC + 2);
    localparam int WAKE_BOUND = WAKE_CYC;

    // wake path: timer plus state hops must stay inside the wake-up time
    if (START_CYC < 1 || START_CYC + 4 > WAKE_CYC) begin : g_bad_timing
        $error("settle count does not fit the wake-up time");
    end

    // ----------------------------------------------------------------
    // gate decode
    // ----------------------------------------------------------------
    function automatic gate_t mode_gates(input mode_t m, input logic bias_used);
        gate_t g;
        g = '1;
        case (m)
            MODE_RUN: begin
                g = '1;                                        // [RULE1]
            end
            MODE_SLP0: begin
                g.cpu  = 1'b0;                                 // [RULE2]
                g.mclk = 1'b0;
            end
            MODE_SLP1: begin
                g.cpu   = 1'b0;                                // [RULE3]
                g.mclk  = 1'b0;
                g.dcgen = bias_used;
            end
            MODE_SLP2: begin
                g.cpu    = 1'b0;                               // [RULE4]
                g.mclk   = 1'b0;
                g.subclk = 1'b0;
            end
            MODE_SLP3: begin
                g.cpu    = 1'b0;                               // [RULE5]
                g.mclk   = 1'b0;
                g.subclk = 1'b0;
                g.dcgen = 1'b0;
            end
            MODE_SLP4: begin
                g = '0;                                        // [RULE6]
            end
            default: begin
                g = '1;
            end
        endcase
        return g;
    endfunction : mode_gates

    function automatic logic valid_mode(input logic [2:0] v);
        return (v <= 3'h5);
    endfunction : valid_mode

    // ----------------------------------------------------------------
    // state and signals
    // ----------------------------------------------------------------
    state_t      st_q;
    mode_t       lvl_q;
    logic        bias_used_q;
    logic        aux_hf_q;
    gate_t       gate_d;
    logic        wake_lvl;
    logic        wake_req;
    logic        acc;
    logic        wr_mode;
    logic        busy;
    logic        tmr_load;
    logic [TW-1:0] tmr_val;
    logic [2:0]  new_mode;

    pin_sync3 u_wake_sync (
        .clk    (clk),
        .resetn (resetn),
        .pin    (wake_pin),
        .level  (wake_lvl)
    );

    assign wake_req = irq_pending | wake_lvl;
    assign acc      = psel & penable & pready;
    assign wr_mode  = acc & pwrite & (paddr == `MODE_CTRL_OFS);
    assign new_mode = pwdata[`MODE_SEL_MSB:`MODE_SEL_LSB];

    // ----------------------------------------------------------------
    // apb slave: answer one cycle into the access phase
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (psel && penable && !pready) begin
            pready  <= 1'b1;
            pslverr <= (paddr != `MODE_CTRL_OFS) && (paddr != `MODE_STATUS_OFS);
            prdata  <= 32'h0000_0000;
            if (!pwrite && paddr == `MODE_CTRL_OFS) begin
                prdata[`MODE_SEL_MSB:`MODE_SEL_LSB] <= lvl_q;
                prdata[`BIAS_USED_BIT]              <= bias_used_q;
                prdata[`AUX_SRC_BIT]                <= aux_hf_q;
            end else if (!pwrite && paddr == `MODE_STATUS_OFS) begin
                prdata[`ST_STATE_LSB +: 2]          <= st_q;
                prdata[`ST_LEVEL_LSB +: 3]          <= lvl_q;
                prdata[`ST_GATES_LSB +: 6]          <= {xtal_en, dcgen_en, aux_clk_en,
                                                        sub_main_clk_en, main_clk_en, cpu_en};
            end
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // mode register; out-of-range mode codes are ignored
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lvl_q      <= MODE_RUN;
            bias_used_q <= 1'(`MODE_CTRL_RESET >> `BIAS_USED_BIT);
            aux_hf_q    <= 1'(`MODE_CTRL_RESET >> `AUX_SRC_BIT);
        end else if (wr_mode) begin
            if (valid_mode(new_mode)) begin
                lvl_q <= mode_t'(new_mode);                    // [RULE8]
            end
            bias_used_q <= pwdata[`BIAS_USED_BIT];
            aux_hf_q    <= pwdata[`AUX_SRC_BIT];              // [RULE11]
        end
    end

    // ----------------------------------------------------------------
    // sleep / wake sequencer
    // ----------------------------------------------------------------
    // restart of the bias generator is only paid when it was switched off
    assign tmr_load = (st_q == ST_SLEEP) && wake_req;
    assign tmr_val  = mode_gates(lvl_q, bias_used_q).dcgen ? TW'(1) : TW'(START_CYC);

    settle_timer #(
        .W (TW)
    ) u_settle (
        .clk      (clk),
        .resetn   (resetn),
        .load     (tmr_load),
        .load_val (tmr_val),
        .busy     (busy)
    );

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= ST_RUN;
        end else begin
            case (st_q)
                ST_RUN: begin
                    if (wr_mode && valid_mode(new_mode) && new_mode != MODE_RUN) begin
                        st_q <= ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    if (lvl_q == MODE_RUN) begin
                        st_q <= ST_RUN;
                    end else if (wake_req) begin
                        st_q <= ST_WAKE;                       // [RULE7]
                    end
                end
                ST_WAKE: begin
                    if (main_clk_en) begin
                        st_q <= ST_ISR;                        // [RULE12]
                    end
                end
                ST_ISR: begin
                    if (irq_return) begin
                        // the handler may have cleared the level to stay awake
                        st_q <= (lvl_q == MODE_RUN) ? ST_RUN : ST_SLEEP; // [RULE7]
                    end
                end
                default: begin
                    st_q <= ST_RUN;
                end
            endcase
        end
    end

    always_comb begin
        case (st_q)
            ST_SLEEP: begin
                gate_d = mode_gates(lvl_q, bias_used_q);
            end
            ST_WAKE: begin
                gate_d       = mode_gates(lvl_q, bias_used_q);
                gate_d.dcgen = 1'b1;                           // [RULE9]
                gate_d.mclk  = !busy && !tmr_load;             // [RULE12]
            end
            default: begin
                gate_d = mode_gates(MODE_RUN, bias_used_q);
            end
        endcase
    end

    // main clock drives the CPU, sub-main clock the peripherals
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cpu_en          <= 1'b1;
            main_clk_en     <= 1'b1;
            sub_main_clk_en <= 1'b1;
            aux_clk_en      <= 1'b1;
            dcgen_en        <= 1'b1;
            xtal_en         <= 1'b1;
            aux_src_hf      <= 1'b0;
        end else begin
            cpu_en          <= gate_d.cpu & gate_d.mclk;       // [RULE10]
            main_clk_en     <= gate_d.mclk;
            sub_main_clk_en <= gate_d.subclk;
            aux_clk_en      <= gate_d.aclk;
            dcgen_en        <= gate_d.dcgen;
            xtal_en         <= gate_d.xtal;
            aux_src_hf      <= aux_hf_q;                       // [RULE11]
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    property p_run_all_on;
        $past(st_q == ST_RUN) |-> cpu_en && main_clk_en && sub_main_clk_en
                                  && aux_clk_en && dcgen_en && xtal_en;
    endproperty
    a_run_all_on: assert property (p_run_all_on) // [RULE1]
        else $error("run mode lost a clock");
    property p_lvl0;
        $past(st_q == ST_SLEEP && lvl_q == MODE_SLP0) |->
            !cpu_en && !main_clk_en && sub_main_clk_en && aux_clk_en;
    endproperty
    a_lvl0: assert property (p_lvl0) // [RULE2]
        else $error("level 0 gating wrong");
    property p_lvl1;
        $past(st_q == ST_SLEEP && lvl_q == MODE_SLP1) |->
            !cpu_en && !main_clk_en && sub_main_clk_en && aux_clk_en
            && (dcgen_en == $past(bias_used_q));
    endproperty
    a_lvl1: assert property (p_lvl1) // [RULE3]
        else $error("level 1 gating wrong");
    property p_lvl2;
        $past(st_q == ST_SLEEP && lvl_q == MODE_SLP2) |->
            !cpu_en && !main_clk_en && !sub_main_clk_en && aux_clk_en && dcgen_en;
    endproperty
    a_lvl2: assert property (p_lvl2) // [RULE4]
        else $error("level 2 gating wrong");
    property p_lvl3;
        $past(st_q == ST_SLEEP && lvl_q == MODE_SLP3) |->
            !cpu_en && !main_clk_en && !sub_main_clk_en && aux_clk_en && !dcgen_en;
    endproperty
    a_lvl3: assert property (p_lvl3) // [RULE5]
        else $error("level 3 gating wrong");
    property p_lvl4;
        $past(st_q == ST_SLEEP && lvl_q == MODE_SLP4) |->
            !cpu_en && !main_clk_en && !sub_main_clk_en && !aux_clk_en
            && !dcgen_en && !xtal_en;
    endproperty
    a_lvl4: assert property (p_lvl4) // [RULE6]
        else $error("level 4 gating wrong");
    property p_return_sleep;
        (st_q == ST_ISR && irq_return && lvl_q != MODE_RUN && !wr_mode)
            |=> st_q == ST_SLEEP ##1 !cpu_en;
    endproperty
    a_return_sleep: assert property (p_return_sleep) // [RULE7]
        else $error("handler return did not re-enter sleep");
    property p_wake_time;
        (st_q == ST_SLEEP && lvl_q != MODE_RUN && wake_req) |->
            ##[1:WAKE_BOUND] cpu_en;
    endproperty
    a_wake_time: assert property (p_wake_time) // [RULE9]
        else $error("wake-up took too long");
    property p_cpu_needs_mclk;
        cpu_en |-> main_clk_en;
    endproperty
    a_cpu_needs_mclk: assert property (p_cpu_needs_mclk) // [RULE10]
        else $error("CPU enabled without main clock");
    property p_aux_src;
        wr_mode |-> ##2 aux_src_hf == $past(pwdata[`AUX_SRC_BIT], 2);
    endproperty
    a_aux_src: assert property (p_aux_src) // [RULE11]
        else $error("aux source select not applied");
    property p_mclk_first;
        $rose(cpu_en) && $past(st_q == ST_WAKE, 2) |-> $past(main_clk_en);
    endproperty
    a_mclk_first: assert property (p_mclk_first) // [RULE12]
        else $error("CPU resumed before main clock");
    property p_level_held;
        (st_q == ST_ISR && !wr_mode) |=> $stable(lvl_q);
    endproperty
    a_level_held: assert property (p_level_held) // [RULE12]
        else $error("saved level changed in handler");

endmodule : lpm_clock_ctrl

`default_nettype wire

// [tb/core_model.sv]
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// core side: raises a wake request and returns from its handler
// ----------------------------------------------------------------
module core_model (
    input  wire logic       clk,         // system clock
    input  wire logic       resetn,      // async reset, active low
    input  wire logic       cpu_en,      // CPU enable from the block
    input  wire logic       arm,         // start one wake-up, one cycle
    input  wire logic       use_irq,     // 1 wake by interrupt line
    input  wire logic [3:0] isr_len,     // handler length, cycles
    output logic            irq_pending, // interrupt request
    output logic            irq_return   // handler return pulse
);
    logic       armed_q;
    logic       busy_q;
    logic [3:0] cnt_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            armed_q     <= 1'b0;
            busy_q      <= 1'b0;
            cnt_q       <= 4'h0;
            irq_pending <= 1'b0;
            irq_return  <= 1'b0;
        end else begin
            irq_return <= 1'b0;
            if (arm) begin
                armed_q     <= 1'b1;
                irq_pending <= use_irq;
            end else if (armed_q && cpu_en && !busy_q) begin
                // request is taken once the CPU runs again
                busy_q      <= 1'b1;
                irq_pending <= 1'b0;
                cnt_q       <= isr_len;
            end else if (busy_q) begin
                if (cnt_q == 4'h0) begin
                    irq_return <= 1'b1;
                    busy_q     <= 1'b0;
                    armed_q    <= 1'b0;
                end else begin
                    cnt_q <= cnt_q - 4'h1;
                end
            end
        end
    end
endmodule : core_model

`default_nettype wire

// [tb/low_power_mode_clock_gating_tb.sv]
`timescale 1ns/1ns
`default_nettype none
`include "lpm_clock_map.svh"

module low_power_mode_clock_gating_tb;
    import lpm_clock_pkg::*;
    localparam int WAKE = 150;
    logic clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, irq_pending, irq_return, wake_pin = 1'b0;
    logic cpu_en, main_clk_en, sub_main_clk_en, aux_clk_en, dcgen_en, xtal_en, aux_src_hf;
    logic arm = 1'b0, use_irq = 1'b0;
    logic [3:0] isr_len = 4'h0;
    int miscompares = 0, comparisons = 0;

    always #20 clk = ~clk;

    lpm_clock_ctrl #(.START_CYC(2), .WAKE_CYC(WAKE)) i_dut (
        .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq_pending(irq_pending), .irq_return(irq_return),
        .wake_pin(wake_pin), .cpu_en(cpu_en), .main_clk_en(main_clk_en),
        .sub_main_clk_en(sub_main_clk_en), .aux_clk_en(aux_clk_en),
        .dcgen_en(dcgen_en), .xtal_en(xtal_en), .aux_src_hf(aux_src_hf));

    core_model i_core (
        .clk(clk), .resetn(resetn), .cpu_en(cpu_en), .arm(arm), .use_irq(use_irq),
        .isr_len(isr_len), .irq_pending(irq_pending), .irq_return(irq_return));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic print_verdict();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : print_verdict

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        // no cycle count assumed: only the watchdog ends a stuck access
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd      = prdata;
        er      = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    function automatic logic [5:0] gates();
        return {xtal_en, dcgen_en, aux_clk_en, sub_main_clk_en, main_clk_en, cpu_en};
    endfunction : gates

    // expected {xtal,dcgen,aclk,subclk,mclk,cpu} for a mode code
    function automatic logic [5:0] exp_g(input logic [2:0] m, input logic bias);
        case (m)
            3'h1:    return 6'h3C;
            3'h2:    return {1'b1, bias, 4'hC};
            3'h3:    return 6'h38;
            3'h4:    return 6'h28;
            3'h5:    return 6'h00;
            default: return 6'h3F;
        endcase
    endfunction : exp_g

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        logic [31:0] rd;
        logic        er;
        check("gates", 32'(gates()), 32'h3F);
        check("aux_src_hf", 32'(aux_src_hf), 32'h0);
        apb(1'b0, `MODE_CTRL_OFS, 32'h0, rd, er);
        check("ctrl", rd, `MODE_CTRL_RESET);
        $display("test reset done");
    endtask : t_reset

    task automatic t_modes();
        logic [31:0] rd;
        logic        er;
        logic [31:0] eg;
        for (int bias = 0; bias < 2; bias++) begin
            for (int m = 1; m < 6; m++) begin
                apb(1'b1, `MODE_CTRL_OFS, 32'(m) | (32'(bias) << `BIAS_USED_BIT), rd, er);
                cyc(4);
                eg = 32'(exp_g(3'(m), 1'(bias)));
                check("sleep", 32'(gates()), eg);
                apb(1'b0, `MODE_STATUS_OFS, 32'h0, rd, er);
                check("sleep state", rd & 32'h3, 32'(ST_SLEEP));
                apb(1'b1, `MODE_CTRL_OFS, 32'(bias) << `BIAS_USED_BIT, rd, er);
                cyc(4);
                check("run gates", 32'(gates()), 32'h3F);
            end
        end
        $display("test modes done");
    endtask : t_modes

    task automatic t_wake(input logic [2:0] m, input logic irq, input logic [3:0] len);
        logic [31:0] rd;
        logic        er, prev;
        int          n;
        apb(1'b1, `MODE_CTRL_OFS, 32'(m), rd, er);
        cyc(4);
        use_irq <= irq;
        isr_len <= len;
        arm     <= 1'b1;
        if (!irq) wake_pin <= 1'b1;
        @(posedge clk);
        arm  <= 1'b0;
        n    = 0;
        prev = 1'b0;
        while (cpu_en !== 1'b1 && n < 300) begin
            prev = main_clk_en;
            @(posedge clk);
            n++;
            // a short pulse: a pin still held would wake the block again after return
            if (n == 3) wake_pin <= 1'b0;
        end
        check("wake in time", 32'(n < WAKE), 32'h1);
        check("main before cpu", 32'(prev), 32'h1);
        n = 0;
        while (cpu_en !== 1'b0 && n < 100) begin
            @(posedge clk);
            n++;
        end
        cyc(3);
        check("back to level", 32'(gates()), 32'(exp_g(m, 1'b0)));
        apb(1'b1, `MODE_CTRL_OFS, 32'h0, rd, er);
        cyc(4);
        $display("test wake done");
    endtask : t_wake

    task automatic t_bus();
        logic [31:0] rd;
        logic        er;
        apb(1'b0, 12'h008, 32'h0, rd, er);
        check("unmapped err", 32'(er), 32'h1);
        check("unmapped data", rd, 32'h0);
        apb(1'b1, 12'h00C, 32'h5, rd, er);
        check("unmapped wr err", 32'(er), 32'h1);
        apb(1'b1, `MODE_CTRL_OFS, 32'h10, rd, er);
        cyc(3);
        check("aux fast src", 32'(aux_src_hf), 32'h1);
        check("still run", 32'(gates()), 32'h3F);
        apb(1'b1, `MODE_CTRL_OFS, 32'h0, rd, er);
        cyc(3);
        check("aux watch src", 32'(aux_src_hf), 32'h0);
        $display("test bus done");
    endtask : t_bus

    initial begin
        #(40 * 20000);
        miscompares++;
        print_verdict();
    end

    initial begin
        cyc(3);
        resetn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_modes();
        for (int m = 1; m < 6; m++) t_wake(3'(m), 1'b1, 4'(2 * m));
        t_wake(3'h5, 1'b0, 4'h0);
        t_wake(3'h4, 1'b0, 4'hF);
        t_bus();
        print_verdict();
    end
endmodule : low_power_mode_clock_gating_tb

`default_nettype wire
